// >>> vtc_table.sv
// vlan action table with wishbone register access and lan/wan lookup ports
//
// Overview of operation
// [R1] table has 4096 entries, init clears all
// [R2] gate bit zero keeps table always enabled
// [R3] rising init control bit starts table init
// [R4] device reset also starts table init
// [R5] auto-increment steps address after data accesses
// [R6] access address register holds 12-bit address
// [R7] entry at access address loads read register
// [R8] write-data write stores entry at address
// [R9] host sets address before writing data
// [R10] read-data read returns entry at address
// [R11] vlan id indexes table directly, 0..4095
// [R12] wan trap bit sends frame to extract
// [R13] mode 5: port-select picks port 1/2
// [R14] lan discard bit drops lan frames
// [R15] lan trap bit sends to lan extract
// [R16] two-bit code picks lan queue group 1-4
// [R17] lan: discard over trap over queue
// [R18] wan: trap overrides port-select forwarding
// [R19] init-done status set when init completes
// [R20] shadow address shows address applied to table
// [R21] auto-increment advances shadow per host data access
// [R22] init default entry value is all zeros
// [R23] arbitrate single port, lose no access
`timescale 1ns/1ps
module vtc_table
    import vtc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [VTC_WB_AW-1:0] wb_adr,
    input wire logic [31:0] wb_wdata,
    input wire logic [3:0] wb_sel,
    input wire logic wb_we,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    output logic [31:0] wb_rdata,
    output logic wb_ack,
    input wire logic lan_req,
    input wire logic [VTC_AW-1:0] lan_vid,
    output vtc_lan_dec_t lan_dec,
    input wire logic wan_req,
    input wire logic [VTC_AW-1:0] wan_vid,
    input wire logic wan_mode5,
    output vtc_wan_dec_t wan_dec,
    output logic table_active
);

    vtc_state_t s_r;
    vtc_state_t s_nxt;
    logic bus_req;
    logic hit_ctl;
    logic hit_addr;
    logic hit_wd;
    logic hit_rd;
    logic hit_shd;

    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : wmerge

    assign bus_req = wb_cyc & wb_stb & ~s_r.ack;
    assign hit_ctl = wb_adr[VTC_WB_AW-1:2] == VTC_IDX_CTL;
    assign hit_addr = wb_adr[VTC_WB_AW-1:2] == VTC_IDX_ADDR;
    assign hit_wd = wb_adr[VTC_WB_AW-1:2] == VTC_IDX_WDATA;
    assign hit_rd = wb_adr[VTC_WB_AW-1:2] == VTC_IDX_RDATA;
    assign hit_shd = wb_adr[VTC_WB_AW-1:2] == VTC_IDX_SHADOW;

    always_comb begin
        logic acc;
        logic op;
        logic lan_go;
        logic wan_go;
        logic [15:0] wv;
        logic [31:0] rd;
        logic [VTC_EW-1:0] e;
        acc = 1'b0;
        op = 1'b0;
        wv = VTC_REG_RESET;
        rd = VTC_RD_NONE;
        e = VTC_ENT_DEFAULT;
        lan_go = lan_req & ~s_r.lan.done;
        wan_go = wan_req & ~s_r.wan.done;
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.lan.done = 1'b0;
        s_nxt.wan.done = 1'b0;
        case (s_r.st)
            VTC_ST_INIT: begin
                // one entry per cycle; lookups and table accesses wait
                s_nxt.mem[s_r.init_cnt] = VTC_ENT_DEFAULT; // R1 R22
                s_nxt.shadow = s_r.init_cnt; // R20
                op = 1'b1;
                s_nxt.init_cnt = s_r.init_cnt + 1'b1;
                if (s_r.init_cnt == VTC_AW'(VTC_DEPTH - 1)) begin
                    s_nxt.st = VTC_ST_RUN;
                    s_nxt.init_done = 1'b1; // R19
                end
            end
            VTC_ST_RUN: begin
                // host write first, then read-data refetch, then lookups in turn
                if (bus_req && hit_wd && wb_we) begin // R23
                    if (wb_sel[0]) begin
                        s_nxt.mem[s_r.addr] = wb_wdata[VTC_EW-1:0]; // R8
                    end
                    s_nxt.shadow = s_r.addr; // R20
                    op = 1'b1;
                    acc = 1'b1;
                    s_nxt.fetch_pend = 1'b1; // R7
                    if (s_r.ctl[VTC_CTL_AUTO_INC]) begin
                        s_nxt.addr = s_r.addr + 1'b1; // R5 R21
                    end
                end else if (s_r.fetch_pend) begin
                    s_nxt.rdata = s_r.mem[s_r.addr]; // R7
                    s_nxt.shadow = s_r.addr; // R20
                    s_nxt.fetch_pend = 1'b0;
                    op = 1'b1;
                end else if (lan_go && (!wan_go || s_r.last_wan)) begin // R23
                    e = s_r.mem[lan_vid]; // R11
                    s_nxt.shadow = lan_vid; // R20
                    s_nxt.last_wan = 1'b0;
                    op = 1'b1;
                    s_nxt.lan.done = 1'b1;
                    s_nxt.lan.discard = e[VTC_ENT_LAN_DISCARD]; // R14
                    s_nxt.lan.extract = e[VTC_ENT_LAN_TRAP] & ~e[VTC_ENT_LAN_DISCARD]; // R15 R17
                    s_nxt.lan.group_en = ~e[VTC_ENT_LAN_TRAP] & ~e[VTC_ENT_LAN_DISCARD]; // R17
                    s_nxt.lan.group = e[VTC_ENT_LAN_GROUP +: 2]; // R16
                end else if (wan_go) begin
                    e = s_r.mem[wan_vid]; // R11
                    s_nxt.shadow = wan_vid; // R20
                    s_nxt.last_wan = 1'b1;
                    op = 1'b1;
                    s_nxt.wan.done = 1'b1;
                    s_nxt.wan.extract = e[VTC_ENT_WAN_TRAP]; // R12
                    s_nxt.wan.port_en = ~e[VTC_ENT_WAN_TRAP] & wan_mode5; // R13 R18
                    s_nxt.wan.port2 = e[VTC_ENT_WAN_PORT]; // R13
                end
            end
            default: begin
                s_nxt.st = VTC_ST_INIT;
                s_nxt.init_cnt = '0;
            end
        endcase
        if (bus_req) begin
            if (hit_ctl) begin
                acc = 1'b1;
                rd = {29'h0, s_r.ctl};
                if (wb_we) begin
                    wv = wmerge({13'h0, s_r.ctl}, wb_wdata, wb_sel);
                    s_nxt.ctl = wv[VTC_CTL_W-1:0];
                    if (wv[VTC_CTL_INIT] && !s_r.ctl[VTC_CTL_INIT]) begin
                        s_nxt.st = VTC_ST_INIT; // R3
                        s_nxt.init_cnt = '0;
                        s_nxt.init_done = 1'b0;
                        s_nxt.fetch_pend = 1'b1;
                    end
                end
            end else if (hit_addr) begin
                acc = 1'b1;
                rd = {20'h0, s_r.addr};
                if (wb_we) begin
                    wv = wmerge({4'h0, s_r.addr}, wb_wdata, wb_sel);
                    s_nxt.addr = wv[VTC_AW-1:0]; // R6
                    s_nxt.fetch_pend = 1'b1; // R7
                end
            end else if (hit_rd) begin
                // a read waits for a pending refetch so it never sees a stale entry
                if (wb_we) begin
                    acc = 1'b1;
                end else if (s_r.st == VTC_ST_RUN && !s_r.fetch_pend) begin
                    acc = 1'b1;
                    rd = {26'h0, s_r.rdata}; // R10
                    if (s_r.ctl[VTC_CTL_AUTO_INC]) begin
                        s_nxt.addr = s_r.addr + 1'b1; // R5 R21
                        s_nxt.fetch_pend = 1'b1;
                    end
                end
            end else if (hit_shd) begin
                acc = 1'b1;
                rd = {19'h0, s_r.init_done, s_r.shadow}; // R19 R20
            end else if (!hit_wd) begin
                acc = 1'b1;
            end else if (!wb_we) begin
                acc = 1'b1;
            end
        end
        if (acc) begin
            s_nxt.ack = 1'b1;
            s_nxt.dat = rd;
        end
        // gated mode trades always-on power for enable only on a table access
        s_nxt.gate = ~s_r.ctl[VTC_CTL_GATE] | op; // R2
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.st <= VTC_ST_INIT; // R4
            s_r.fetch_pend <= 1'b1;
            s_r.gate <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_rdata = s_r.dat;
    assign wb_ack = s_r.ack;
    assign lan_dec = s_r.lan;
    assign wan_dec = s_r.wan;
    assign table_active = s_r.gate;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    property p_init_clears;
        $rose(s_r.init_done) |-> s_r.mem[0] == VTC_ENT_DEFAULT && s_r.mem[VTC_DEPTH-1] == VTC_ENT_DEFAULT;
    endproperty
    a_init_clears: assert property (p_init_clears) else $error("table not cleared at init end"); // R1

    property p_gate_full;
        !s_r.ctl[VTC_CTL_GATE] |=> table_active;
    endproperty
    a_gate_full: assert property (p_gate_full) else $error("table not enabled with gate bit clear"); // R2

    property p_init_start;
        wb_ack && wb_cyc && wb_stb && wb_we && hit_ctl && wb_sel[0] && wb_wdata[VTC_CTL_INIT]
            && !$past(s_r.ctl[VTC_CTL_INIT]) |-> s_r.st == VTC_ST_INIT && !s_r.init_done;
    endproperty
    a_init_start: assert property (p_init_start) else $error("init not started on rising control bit"); // R3

    property p_done_only_run;
        s_r.init_done |-> s_r.st == VTC_ST_RUN;
    endproperty
    a_done_only_run: assert property (p_done_only_run) else $error("init done shown while init runs"); // R19

    property p_auto_inc;
        wb_ack && wb_cyc && wb_stb && !wb_we && hit_rd && s_r.ctl[VTC_CTL_AUTO_INC]
            |-> s_r.addr == VTC_AW'($past(s_r.addr) + 1'b1);
    endproperty
    a_auto_inc: assert property (p_auto_inc) else $error("address not stepped after data read"); // R5

    property p_write_store;
        wb_ack && wb_cyc && wb_stb && wb_we && hit_wd && wb_sel[0]
            |-> s_r.mem[$past(s_r.addr)] == $past(wb_wdata[VTC_EW-1:0]);
    endproperty
    a_write_store: assert property (p_write_store) else $error("write data not stored in table"); // R8

    property p_read_ret;
        wb_ack && wb_cyc && wb_stb && !wb_we && hit_rd |-> wb_rdata[VTC_EW-1:0] == $past(s_r.mem[s_r.addr]);
    endproperty
    a_read_ret: assert property (p_read_ret) else $error("read data differs from table entry"); // R10

    property p_lan_prio;
        lan_dec.done |-> (lan_dec.discard ? !lan_dec.extract && !lan_dec.group_en
            : lan_dec.extract != lan_dec.group_en);
    endproperty
    a_lan_prio: assert property (p_lan_prio) else $error("lan action precedence broken"); // R17

    property p_lan_group;
        lan_dec.done && lan_dec.group_en |-> lan_dec.group == $past(s_r.mem[lan_vid][1:0]);
    endproperty
    a_lan_group: assert property (p_lan_group) else $error("lan group not from entry"); // R16

    property p_wan_prio;
        wan_dec.done && wan_dec.extract |-> !wan_dec.port_en;
    endproperty
    a_wan_prio: assert property (p_wan_prio) else $error("wan trap did not override port select"); // R18

    property p_shadow_lan;
        lan_dec.done |-> s_r.shadow == $past(lan_vid);
    endproperty
    a_shadow_lan: assert property (p_shadow_lan) else $error("shadow address not lookup address"); // R20

    // the done cycle itself still sees req high, so it is left out
    property p_lan_served;
        lan_req && !lan_dec.done && s_r.st == VTC_ST_RUN && !s_r.fetch_pend && !bus_req |-> ##[1:4] lan_dec.done;
    endproperty
    a_lan_served: assert property (p_lan_served) else $error("lan lookup starved"); // R23

    property p_wan_served;
        wan_req && !wan_dec.done && s_r.st == VTC_ST_RUN && !s_r.fetch_pend && !bus_req |-> ##[1:4] wan_dec.done;
    endproperty
    a_wan_served: assert property (p_wan_served) else $error("wan lookup starved"); // R23

    property p_gate_idle;
        s_r.ctl[VTC_CTL_GATE] && s_r.st == VTC_ST_RUN && !s_r.fetch_pend && !bus_req && !lan_req && !wan_req
            |=> !table_active;
    endproperty
    a_gate_idle: assert property (p_gate_idle) else $error("gated table stayed enabled while idle"); // R2

    property p_init_shadow;
        s_r.st == VTC_ST_INIT |=> s_r.shadow == $past(s_r.init_cnt);
    endproperty
    a_init_shadow: assert property (p_init_shadow) else $error("shadow not init address"); // R20

    property p_init_end;
        s_r.st == VTC_ST_INIT && s_r.init_cnt == VTC_AW'(VTC_DEPTH - 1) && !bus_req
            |=> s_r.st == VTC_ST_RUN && s_r.init_done;
    endproperty
    a_init_end: assert property (p_init_end) else $error("init done not set after last entry"); // R19

    property p_fetch_load;
        s_r.fetch_pend && s_r.st == VTC_ST_RUN && !(bus_req && hit_wd && wb_we)
            |=> s_r.rdata == $past(s_r.mem[s_r.addr]);
    endproperty
    a_fetch_load: assert property (p_fetch_load) else $error("read register not loaded from table"); // R7

    property p_lan_discard;
        lan_dec.done |-> lan_dec.discard == $past(s_r.mem[lan_vid][VTC_ENT_LAN_DISCARD]);
    endproperty
    a_lan_discard: assert property (p_lan_discard) else $error("lan discard not from entry"); // R14

    property p_lan_trap;
        lan_dec.done && !lan_dec.discard |-> lan_dec.extract == $past(s_r.mem[lan_vid][VTC_ENT_LAN_TRAP]);
    endproperty
    a_lan_trap: assert property (p_lan_trap) else $error("lan trap not from entry"); // R15

    property p_wan_trap;
        wan_dec.done |-> wan_dec.extract == $past(s_r.mem[wan_vid][VTC_ENT_WAN_TRAP]);
    endproperty
    a_wan_trap: assert property (p_wan_trap) else $error("wan trap not from entry"); // R12

    property p_wan_port;
        wan_dec.done |-> wan_dec.port2 == $past(s_r.mem[wan_vid][VTC_ENT_WAN_PORT])
            && wan_dec.port_en == (!wan_dec.extract && $past(wan_mode5));
    endproperty
    a_wan_port: assert property (p_wan_port) else $error("wan port select wrong"); // R13

    property p_shadow_wan;
        wan_dec.done |-> s_r.shadow == $past(wan_vid);
    endproperty
    a_shadow_wan: assert property (p_shadow_wan) else $error("shadow address not wan lookup address"); // R20

    c_init_done: cover property ($rose(s_r.init_done));
    c_lan_lookup: cover property (lan_dec.done && lan_dec.extract);
    c_wan_lookup: cover property (wan_dec.done && wan_dec.port_en);
    c_host_write: cover property (wb_ack && wb_we && hit_wd);

endmodule : vtc_table

// >>> vtc_pkg.sv
// shared constants and carrier types of the vlan action table
package vtc_pkg;

    // table geometry
    localparam int VTC_DEPTH = 4096;
    localparam int VTC_AW = 12;
    localparam int VTC_EW = 6;
    localparam int VTC_WB_AW = 12;

    // register indices; byte address is four times the index
    localparam logic [9:0] VTC_IDX_CTL = 10'h080;
    localparam logic [9:0] VTC_IDX_ADDR = 10'h082;
    localparam logic [9:0] VTC_IDX_WDATA = 10'h084;
    localparam logic [9:0] VTC_IDX_RDATA = 10'h086;
    localparam logic [9:0] VTC_IDX_SHADOW = 10'h088;

    // control register fields
    localparam int VTC_CTL_AUTO_INC = 0;
    localparam int VTC_CTL_INIT = 1;
    localparam int VTC_CTL_GATE = 2;
    localparam int VTC_CTL_W = 3;

    // shadow register field
    localparam int VTC_SHD_INIT_DONE = 12;

    // entry fields
    localparam int VTC_ENT_LAN_GROUP = 0;
    localparam int VTC_ENT_LAN_TRAP = 2;
    localparam int VTC_ENT_LAN_DISCARD = 3;
    localparam int VTC_ENT_WAN_PORT = 4;
    localparam int VTC_ENT_WAN_TRAP = 5;

    // reset and default values
    localparam logic [VTC_EW-1:0] VTC_ENT_DEFAULT = 6'h00;
    localparam logic [15:0] VTC_REG_RESET = 16'h0000;
    localparam logic [31:0] VTC_RD_NONE = 32'h0000_0000;

    typedef enum logic [1:0] {
        VTC_ST_INIT = 2'b01,
        VTC_ST_RUN = 2'b10
    } vtc_state_e_t;

    typedef struct packed {
        logic done;
        logic discard;
        logic extract;
        logic group_en;
        logic [1:0] group;
    } vtc_lan_dec_t;

    typedef struct packed {
        logic done;
        logic extract;
        logic port_en;
        logic port2;
    } vtc_wan_dec_t;

    typedef struct packed {
        logic [VTC_DEPTH-1:0][VTC_EW-1:0] mem;
        vtc_state_e_t st;
        logic [VTC_CTL_W-1:0] ctl;
        logic [VTC_AW-1:0] addr;
        logic [VTC_EW-1:0] rdata;
        logic [VTC_AW-1:0] shadow;
        logic [VTC_AW-1:0] init_cnt;
        logic init_done;
        logic fetch_pend;
        logic last_wan;
        logic gate;
        logic ack;
        logic [31:0] dat;
        vtc_lan_dec_t lan;
        vtc_wan_dec_t wan;
    } vtc_state_t;

endpackage : vtc_pkg

// >>> vtc_table_tb.sv
// self-checking bench for the vlan action table
`timescale 1ns/1ps
module vtc_table_tb_top
    import vtc_pkg::*;
;
    localparam logic [11:0] A_CTL = {VTC_IDX_CTL, 2'b00};
    localparam logic [11:0] A_ADDR = {VTC_IDX_ADDR, 2'b00};
    localparam logic [11:0] A_WD = {VTC_IDX_WDATA, 2'b00};
    localparam logic [11:0] A_RD = {VTC_IDX_RDATA, 2'b00};
    localparam logic [11:0] A_SH = {VTC_IDX_SHADOW, 2'b00};
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] wb_adr = 12'h000;
    logic [31:0] wb_wdata = 32'h0000_0000;
    logic [3:0] wb_sel = 4'h0;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic [31:0] wb_rdata;
    logic wb_ack;
    logic lan_req = 1'b0;
    logic [11:0] lan_vid = 12'h000;
    vtc_lan_dec_t lan_dec;
    logic wan_req = 1'b0;
    logic [11:0] wan_vid = 12'h000;
    logic wan_mode5 = 1'b0;
    vtc_wan_dec_t wan_dec;
    logic table_active;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [15:0] rd;
    logic [15:0] got_l;
    logic [15:0] got_w;
    int n;
    // lan group 1 / port 2 / wan trap over port / lan discard over trap
    logic [5:0] ent [4] = '{6'h00, 6'h11, 6'h36, 6'h0F};

    vtc_table vtc_table_i (.clk_sys(clk_sys), .rst_b(rst_b), .wb_adr(wb_adr), .wb_wdata(wb_wdata),
        .wb_sel(wb_sel), .wb_we(wb_we), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_rdata(wb_rdata),
        .wb_ack(wb_ack), .lan_req(lan_req), .lan_vid(lan_vid), .lan_dec(lan_dec), .wan_req(wan_req),
        .wan_vid(wan_vid), .wan_mode5(wan_mode5), .wan_dec(wan_dec), .table_active(table_active));

    always #10 clk_sys = ~clk_sys;

    task automatic tally_and_finish();
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // hang guard well above two full inits plus traffic
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // ack is read at the edge itself, before that edge's updates land
    task automatic wb(input logic we, input logic [11:0] adr, input logic [15:0] wd, output logic [15:0] q);
        int k;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'h3;
        wb_wdata <= {16'h0000, wd};
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wb_ack !== 1'b1 && k < 6000);
        q = wb_rdata[15:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (k >= 6000) miscompares++;
    endtask : wb

    task automatic look(input logic wan, input logic [11:0] vid, output logic [15:0] q);
        int k;
        @(posedge clk_sys);
        if (wan) begin
            wan_req <= 1'b1;
            wan_vid <= vid;
        end else begin
            lan_req <= 1'b1;
            lan_vid <= vid;
        end
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while ((wan ? wan_dec.done : lan_dec.done) !== 1'b1 && k < 100);
        if (wan) begin
            q = {13'h0000, wan_dec.extract, wan_dec.port_en, wan_dec.port_en & wan_dec.port2};
            wan_req <= 1'b0;
        end else begin
            q = {11'h000, lan_dec.discard, lan_dec.extract, lan_dec.group_en,
                lan_dec.group & {2{lan_dec.group_en}}};
            lan_req <= 1'b0;
        end
        if (k >= 100) miscompares++;
    endtask : look

    function automatic logic [15:0] lan_exp(input logic [5:0] e);
        lan_exp = {11'h000, e[3], !e[3] & e[2], !e[3] & !e[2], e[1:0] & {2{!e[3] & !e[2]}}};
    endfunction : lan_exp

    function automatic logic [15:0] wan_exp(input logic [5:0] e, input logic m);
        wan_exp = {13'h0000, e[5], !e[5] & m, !e[5] & m & e[4]};
    endfunction : wan_exp

    task automatic wait_init();
        n = 0;
        do begin
            wb(1'b0, A_SH, 16'h0000, rd);
            n++;
        end while (rd[VTC_SHD_INIT_DONE] !== 1'b1 && n < 3000);
        chk({15'h0000, rd[VTC_SHD_INIT_DONE]}, 16'h0001);
    endtask : wait_init

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        wb(1'b0, A_SH, 16'h0000, rd);
        chk(rd & 16'h1000, 16'h0000);
        wb(1'b0, A_CTL, 16'h0000, rd);
        chk(rd, VTC_REG_RESET);
        wb(1'b0, A_ADDR, 16'h0000, rd);
        chk(rd, VTC_REG_RESET);
        wait_init();
        chk({15'h0000, table_active}, 16'h0001);
        wb(1'b1, A_CTL, 16'h0001, rd);
        wb(1'b0, A_CTL, 16'h0000, rd);
        chk(rd, 16'h0001);
        // top of the table, stepped by auto-increment
        wb(1'b1, A_ADDR, 16'h0FFC, rd);
        for (int i = 0; i < 4; i++) wb(1'b1, A_WD, {10'h000, ent[i]}, rd);
        wb(1'b1, A_ADDR, 16'h0FFC, rd);
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, A_RD, 16'h0000, rd);
            chk(rd, {10'h000, ent[i]});
            wb(1'b0, A_SH, 16'h0000, rd);
            if (i < 3) chk(rd, {4'h1, 12'hFFC + 12'(i + 1)});
        end
        // lan and wan requests together, both forwarding modes
        for (int j = 0; j < 8; j++) begin
            @(posedge clk_sys);
            wan_mode5 <= j[2];
            fork
                look(1'b0, 12'hFFC + 12'(j % 4), got_l);
                look(1'b1, 12'hFFC + 12'(j % 4), got_w);
            join
            chk(got_l, lan_exp(ent[j % 4]));
            chk(got_w, wan_exp(ent[j % 4], j[2]));
        end
        look(1'b0, 12'hFFE, got_l);
        wb(1'b0, A_SH, 16'h0000, rd);
        chk(rd, 16'h1FFE);
        wb(1'b1, 12'h300, 16'hFFFF, rd);
        wb(1'b0, 12'h300, 16'h0000, rd);
        chk(rd, 16'h0000);
        wb(1'b1, A_CTL, 16'h0004, rd);
        repeat (4) @(posedge clk_sys);
        chk({15'h0000, table_active}, 16'h0000);
        // fresh rising edge of the init bit clears every table entry
        wb(1'b1, A_CTL, 16'h0006, rd);
        wb(1'b0, A_SH, 16'h0000, rd);
        chk(rd & 16'h1000, 16'h0000);
        wait_init();
        look(1'b0, 12'hFFF, got_l);
        chk(got_l, lan_exp(VTC_ENT_DEFAULT));
        wb(1'b1, A_ADDR, 16'h0FFD, rd);
        wb(1'b0, A_RD, 16'h0000, rd);
        chk(rd, 16'h0000);
        tally_and_finish();
    end
endmodule : vtc_table_tb_top
